// ===== dv/dcc_net_model.sv
`timescale 1ns/1ps
module dcc_net_model (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_nrst,
    // Link requests from the block
    input wire logic i_tcp_syn,
    input wire logic i_udp_empty_dgram,
    input wire logic i_tcp_fin,
    input wire logic i_tcp_rst,
    input wire logic i_udp_drop,
    // Answer latency in cycles, zero never answers
    input wire logic [7:0] i_lat,
    // Link events back to the block
    output logic o_link_up,
    output logic o_link_down
);
    logic [7:0] up_cnt_reg;
    logic [7:0] down_cnt_reg;

    always_ff @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            up_cnt_reg <= 8'h00;
            o_link_up <= 1'b0;
        end
        else
        begin
            o_link_up <= (up_cnt_reg == 8'h01);
            if (i_tcp_syn || i_udp_empty_dgram)
                up_cnt_reg <= i_lat;
            else if (up_cnt_reg != 8'h00)
                up_cnt_reg <= up_cnt_reg - 8'h01;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            down_cnt_reg <= 8'h00;
            o_link_down <= 1'b0;
        end
        else
        begin
            o_link_down <= (down_cnt_reg == 8'h01);
            // UDP is discarded at once, so no late link-down follows
            if (i_tcp_fin || i_tcp_rst)
                down_cnt_reg <= i_lat;
            else if (i_udp_drop)
                down_cnt_reg <= 8'h00;
            else if (down_cnt_reg != 8'h00)
                down_cnt_reg <= down_cnt_reg - 8'h01;
        end
    end
endmodule : dcc_net_model

// ===== dv/testbench.sv
`timescale 1ns/1ps
module testbench
    import dcc_pkg::*;
;
    logic i_clk_sys = 1'b0;
    logic i_nrst = 1'b0;
    logic [5:0] i_address = 6'h00;
    logic i_read = 1'b0;
    logic i_write = 1'b0;
    logic [31:0] i_writedata = 32'h0;
    logic [3:0] i_byteenable = 4'hf;
    logic i_addr_obtained = 1'b0;
    logic i_incoming_accepted = 1'b0;
    logic [1:0] i_ovf_set = 2'h0;
    logic [7:0] net_lat = 8'h14;
    logic [31:0] o_readdata, o_dest_ip, rd;
    logic [15:0] o_dest_port;
    logic [1:0] o_ovf_flags;
    wire o_waitrequest, o_tcp_syn, o_udp_empty_dgram, o_tcp_fin, o_tcp_rst, o_udp_drop;
    wire o_conn_flag, o_irq, i_link_up, i_link_down;
    int fail_count = 0;
    int checked = 0;

    always #12.5 i_clk_sys = ~i_clk_sys;

    dcc_conn_ctrl dut_u (.i_clk_sys, .i_nrst, .i_address, .i_read, .i_write, .i_writedata,
        .i_byteenable, .o_readdata, .o_waitrequest, .i_addr_obtained, .i_incoming_accepted,
        .i_link_up, .i_link_down, .i_ovf_set, .o_tcp_syn, .o_udp_empty_dgram, .o_tcp_fin,
        .o_tcp_rst, .o_udp_drop, .o_dest_ip, .o_dest_port, .o_ovf_flags, .o_conn_flag, .o_irq);

    dcc_net_model net_u (.i_clk_sys, .i_nrst, .i_tcp_syn(o_tcp_syn),
        .i_udp_empty_dgram(o_udp_empty_dgram), .i_tcp_fin(o_tcp_fin), .i_tcp_rst(o_tcp_rst),
        .i_udp_drop(o_udp_drop), .i_lat(net_lat), .o_link_up(i_link_up),
        .o_link_down(i_link_down));

    task summarize;
        $display("checks %0d errors %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : summarize

    task chk(input logic [63:0] got, input logic [63:0] exp, input string what);
        checked++;
        if (got !== exp)
        begin
            fail_count++;
            $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    // Holds the request until waitrequest is seen low at an edge
    task bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
        @(posedge i_clk_sys);
        i_address <= a;
        i_write <= wr;
        i_read <= !wr;
        i_writedata <= d;
        do
            @(posedge i_clk_sys);
        while (o_waitrequest !== 1'b0);
        rd = o_readdata;
        i_write <= 1'b0;
        i_read <= 1'b0;
    endtask : bus

    task wr(input logic [5:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask : wr

    task rdchk(input logic [5:0] a, input logic [31:0] e, input string what);
        bus(1'b0, a, 32'h0);
        chk(rd, e, what);
    endtask : rdchk

    // Link pulses in the cycle after the command edge: syn,dgram,fin,rst,drop
    task pl(input logic [4:0] e);
        #1;
        chk({o_tcp_syn, o_udp_empty_dgram, o_tcp_fin, o_tcp_rst, o_udp_drop}, e, "pulse");
    endtask : pl

    task rep(input logic [7:0] e);
        bus(1'b0, DCC_OFS_STATUS, 32'h0);
        chk(rd[11:4], e, "reply");
    endtask : rep

    task wst(input logic [1:0] s);
        int n;
        n = 0;
        do
        begin
            bus(1'b0, DCC_OFS_STATUS, 32'h0);
            n++;
        end
        while (rd[1:0] !== s && n < 40);
        chk(rd[1:0], s, "state");
    endtask : wst

    task t_reset;
        chk({o_conn_flag, o_irq, o_ovf_flags, o_dest_ip, o_dest_port}, 64'h0,
            "reset outputs");
        rdchk(DCC_OFS_STATUS, 32'h0, "status");
        rdchk(DCC_OFS_IRQ_MASK, 32'h0, "mask");
        rdchk(6'h3c, 32'h0, "unmapped");
        wr(6'h3c, 32'hffff_ffff);
        i_byteenable <= 4'h3;
        wr(DCC_OFS_CFG, 32'h0);
        i_byteenable <= 4'hf;
        rdchk(DCC_OFS_CFG, {28'h0, DCC_CFG_RST}, "cfg");
    endtask : t_reset

    task t_udp;
        wr(DCC_OFS_PARAM_IP, 32'h0a00_0001);
        wr(DCC_OFS_PARAM_PORT, 32'h1234);
        wr(DCC_OFS_CMD, 32'h1);
        pl(5'b01000); // empty datagram
        chk({o_dest_ip, o_dest_port}, {32'h0a00_0001, 16'h1234}, "dest");
        rep(DCC_REPLY_OK); // reply before link up
        wr(DCC_OFS_CMD, 32'h1);
        rep(DCC_REPLY_REJ); // open while opening
        wst(DCC_OPENING);
        wst(DCC_ESTABLISHED);
        chk(o_conn_flag, 1'b1, "conn flag");
        wr(DCC_OFS_PARAM_IP, 32'h0b00_0002);
        i_ovf_set <= 2'h3;
        @(posedge i_clk_sys);
        i_ovf_set <= 2'h0;
        #1;
        chk(o_ovf_flags, 2'h3, "ovf set");
        wr(DCC_OFS_CMD, 32'h2);
        pl(5'b00001); // udp drop
        chk(o_ovf_flags, 2'h0, "ovf cleared");
        rep(DCC_REPLY_OK);
        wst(DCC_CLOSED);
        wr(DCC_OFS_CMD, 32'h1);
        pl(5'b01000);
        chk(o_dest_ip, 32'h0a00_0001, "param kept");
        wst(DCC_ESTABLISHED);
        wr(DCC_OFS_CMD, 32'h3);
        pl(5'b00001); // udp drop
        wst(DCC_CLOSED);
    endtask : t_udp

    task t_tcp;
        wr(DCC_OFS_CFG, 32'h5);
        wr(DCC_OFS_ARG_IP, 32'hc0a8_0105);
        wr(DCC_OFS_ARG_PORT, 32'hffff);
        wr(DCC_OFS_CMD, 32'h31);
        pl(5'b10000); // syn
        chk({o_dest_ip, o_dest_port}, {32'hc0a8_0105, 16'hffff}, "arg dest");
        wst(DCC_ESTABLISHED);
        wr(DCC_OFS_CMD, 32'h2);
        pl(5'b00100); // orderly fin
        rep(DCC_REPLY_OK);
        wst(DCC_CLOSING);
        wst(DCC_CLOSED);
        wr(DCC_OFS_ARG_PORT, 32'h0);
        wr(DCC_OFS_CMD, 32'h31);
        pl(5'b10000);
        chk(o_dest_port, 16'h0, "port zero");
        wst(DCC_ESTABLISHED);
        wr(DCC_OFS_CMD, 32'h3);
        pl(5'b00010); // tcp reset
        wst(DCC_CLOSED);
    endtask : t_tcp

    task t_err;
        logic [31:0] bad [4];
        bad = '{32'h11, 32'h21, 32'h71, 32'h5};
        foreach (bad[i])
        begin
            wr(DCC_OFS_CMD, bad[i]);
            pl(5'b00000);
            rep(DCC_REPLY_ERR);
        end
        wst(DCC_CLOSED);
    endtask : t_err

    task t_rej;
        wr(DCC_OFS_CFG, 32'h0);
        wr(DCC_OFS_CMD, 32'h1);
        rep(DCC_REPLY_REJ); // server only
        wr(DCC_OFS_CFG, 32'h9);
        wr(DCC_OFS_CMD, 32'h1);
        rep(DCC_REPLY_REJ); // no address yet
        i_addr_obtained <= 1'b1;
        net_lat <= 8'h02;
        wr(DCC_OFS_CFG, 32'ha);
        wr(DCC_OFS_CMD, 32'h1);
        pl(5'b01000); // client role
        rep(DCC_REPLY_OK);
        wst(DCC_ESTABLISHED);
        wr(DCC_OFS_CMD, 32'h3);
        wst(DCC_CLOSED);
    endtask : t_rej

    task t_passive;
        wr(DCC_OFS_CFG, 32'h1);
        wr(DCC_OFS_SET_IP, 32'h0c00_0003);
        wr(DCC_OFS_SET_PORT, 32'h0050);
        wr(DCC_OFS_PARAM_PORT, 32'h0051);
        i_incoming_accepted <= 1'b1;
        @(posedge i_clk_sys);
        i_incoming_accepted <= 1'b0;
        wst(DCC_ESTABLISHED);
        wr(DCC_OFS_CMD, 32'h2);
        rep(DCC_REPLY_OK); // passive close
        wst(DCC_CLOSED);
        wr(DCC_OFS_CMD, 32'h2);
        pl(5'b00000); // idle close
        rep(DCC_REPLY_OK);
        wr(DCC_OFS_CMD, 32'h1);
        pl(5'b01000);
        chk({o_dest_ip, o_dest_port}, {32'h0c00_0003, 16'h0050}, "stored dest");
        wst(DCC_ESTABLISHED);
        wr(DCC_OFS_CMD, 32'h3);
        wst(DCC_CLOSED);
    endtask : t_passive

    task t_irq;
        wr(DCC_OFS_IRQ_STAT, 32'h7);
        chk(o_irq, 1'b0, "irq idle");
        wr(DCC_OFS_IRQ_MASK, 32'h1);
        wr(DCC_OFS_CMD, 32'h3);
        rdchk(DCC_OFS_IRQ_STAT, 32'h1, "irq stat");
        chk(o_irq, 1'b1, "irq up");
        wr(DCC_OFS_IRQ_STAT, 32'h1);
        #1;
        chk(o_irq, 1'b0, "irq cleared");
        wr(DCC_OFS_CMD, 32'h2);
        wr(DCC_OFS_IRQ_MASK, 32'h0);
        #1;
        chk(o_irq, 1'b0, "irq masked");
    endtask : t_irq

    initial
    begin
        repeat (20) @(posedge i_clk_sys);
        i_nrst <= 1'b1;
        t_reset();
        t_udp();
        t_tcp();
        t_err();
        t_rej();
        t_passive();
        t_irq();
        summarize();
    end

    // Whole sequence needs well under two thousand cycles
    initial
    begin
        repeat (6000) @(posedge i_clk_sys);
        fail_count++;
        $display("ERROR %0t watchdog expired", $time);
        summarize();
    end
endmodule : testbench

// ===== rtl/dcc_conn_ctrl.sv
// Local design decisions: the register addresses and register access over Avalon-MM.
`timescale 1ns/1ps
// Functional notes
// (R1) Open uses TCP or UDP per the current transport selection.
// (R2) Optional destination is IP plus port 0-65535, both or neither.
// (R3) Open with only one destination field is malformed, never accepted.
// (R4) No fields, no incoming since parameters: use parameter endpoint.
// (R5) No fields, incoming accepted since parameters: reload stored settings endpoint.
// (R6) TCP open starts SYN handshake; UDP open sends one empty datagram.
// (R7) Open replies OK on acceptance, not on completion.
// (R8) Invalid data or partial destination gives error reply.
// (R9) Auto addressing on with no address yet gives rejected reply.
// (R10) Open rejected unless connection state is closed.
// (R11) Open rejected when routing role is server-only.
// (R12) Open meaningful only in server/client or client-only roles; code rejects only the server role, so role value 3 also opens.
// (R13) Close drops UDP at once, TCP via orderly FIN exchange.
// (R14) Abort drops UDP, resets TCP with an RST packet.
// (R15) Close and abort clear routing buffer overflow flags.
// (R16) Close and abort accepted at any time, even passive or idle.
// (R17) Close and abort always reply OK; teardown completes later.
// (R18) Destination parameter changes refused while a connection is active.
// (R19) Explicit state closed/opening/established/closing drives rejection and flag.
module dcc_conn_ctrl
    import dcc_pkg::*;
(
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_nrst,
    // Avalon-MM slave
    input wire logic [5:0] i_address,
    input wire logic i_read,
    input wire logic i_write,
    input wire logic [31:0] i_writedata,
    input wire logic [3:0] i_byteenable,
    output logic [31:0] o_readdata,
    output logic o_waitrequest,
    // Network engine, same clock
    input wire logic i_addr_obtained,
    input wire logic i_incoming_accepted,
    input wire logic i_link_up,
    input wire logic i_link_down,
    input wire logic [1:0] i_ovf_set,
    output logic o_tcp_syn,
    output logic o_udp_empty_dgram,
    output logic o_tcp_fin,
    output logic o_tcp_rst,
    output logic o_udp_drop,
    output logic [31:0] o_dest_ip,
    output logic [15:0] o_dest_port,
    // Status and interrupt
    output logic [1:0] o_ovf_flags,
    output logic o_conn_flag,
    output logic o_irq
);

    dcc_state_t state_reg;
    logic [3:0] cfg_reg;
    logic [31:0] param_ip_reg;
    logic [15:0] param_port_reg;
    logic [31:0] set_ip_reg;
    logic [15:0] set_port_reg;
    logic [31:0] arg_ip_reg;
    logic [15:0] arg_port_reg;
    logic incoming_since_reg;
    logic [7:0] reply_reg;
    logic [1:0] ovf_reg;
    logic [2:0] irq_stat_reg;
    logic [2:0] irq_mask_reg;
    logic tcp_reg;
    logic [31:0] dest_ip_reg;
    logic [15:0] dest_port_reg;
    logic [4:0] pulse_reg;
    logic [31:0] rdata_next;

    // Single-cycle accept; only full-word writes are honoured
    function automatic logic wr_hit(input logic [5:0] ofs);
        wr_hit = i_write && (i_address == ofs) && (i_byteenable == 4'hf);
    endfunction : wr_hit

    logic cmd_wr;
    logic [3:0] op;
    logic has_ip;
    logic has_port;
    logic [1:0] role;
    logic open_cmd;
    logic drop_cmd;
    logic open_err;
    logic open_rej;
    logic param_ok;

    assign cmd_wr = wr_hit(DCC_OFS_CMD);
    assign op = i_writedata[DCC_CMD_OP_LSB +: 4];
    assign has_ip = i_writedata[DCC_CMD_HAS_IP];
    assign has_port = i_writedata[DCC_CMD_HAS_PORT];
    assign role = cfg_reg[DCC_CFG_ROLE_LSB +: 2];
    assign open_cmd = cmd_wr && (op == DCC_OP_OPEN);
    assign drop_cmd = cmd_wr && ((op == DCC_OP_CLOSE) || (op == DCC_OP_ABORT));
    // (R3) partial destination
    // Unknown opcodes and an out-of-range port flag also count as invalid data
    assign open_err = (has_ip != has_port) || i_writedata[DCC_CMD_PORT_HI];
    // (R9) address not ready, (R10) not closed, (R11) server role
    assign open_rej = (cfg_reg[DCC_CFG_AUTO_ADDR] && !i_addr_obtained)
        || (state_reg != DCC_CLOSED)
        || (role == DCC_ROLE_SERVER);
    // (R18) parameter writes refused while not closed
    assign param_ok = (state_reg == DCC_CLOSED)
        && !(cfg_reg[DCC_CFG_AUTO_ADDR] && !i_addr_obtained);

    assign o_waitrequest = 1'b0;

    // Config and destination parameters
    always_ff @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            cfg_reg <= DCC_CFG_RST;
            param_ip_reg <= 32'h0;
            param_port_reg <= 16'h0;
            set_ip_reg <= 32'h0;
            set_port_reg <= 16'h0;
            arg_ip_reg <= 32'h0;
            arg_port_reg <= 16'h0;
            irq_mask_reg <= DCC_IRQ_MASK_RST;
        end
        else
        begin
            if (wr_hit(DCC_OFS_CFG))
                cfg_reg <= i_writedata[3:0];
            if (wr_hit(DCC_OFS_SET_IP))
                set_ip_reg <= i_writedata;
            if (wr_hit(DCC_OFS_SET_PORT))
                set_port_reg <= i_writedata[15:0];
            if (wr_hit(DCC_OFS_ARG_IP))
                arg_ip_reg <= i_writedata;
            // (R2) port field is 16 bits, 0-65535
            if (wr_hit(DCC_OFS_ARG_PORT))
                arg_port_reg <= i_writedata[15:0];
            // (R18) destination fixed during connection
            if (wr_hit(DCC_OFS_PARAM_IP) && param_ok)
                param_ip_reg <= i_writedata;
            if (wr_hit(DCC_OFS_PARAM_PORT) && param_ok)
                param_port_reg <= i_writedata[15:0];
            if (wr_hit(DCC_OFS_IRQ_MASK))
                irq_mask_reg <= i_writedata[2:0];
        end
    end

    // Incoming-since-parameters tracker; a new accept wins over a param write
    always_ff @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
            incoming_since_reg <= 1'b0;
        else if (i_incoming_accepted)
            incoming_since_reg <= 1'b1;
        else if ((wr_hit(DCC_OFS_PARAM_IP) || wr_hit(DCC_OFS_PARAM_PORT)) && param_ok)
            incoming_since_reg <= 1'b0;
    end

    // (R19) connection state machine
    always_ff @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            state_reg <= DCC_CLOSED;
            tcp_reg <= 1'b0;
            dest_ip_reg <= 32'h0;
            dest_port_reg <= 16'h0;
        end
        else if (drop_cmd)
        begin
            // (R16) teardown accepted in any state
            // (R13) UDP drops at once; TCP close or abort waits in closing for link down
            state_reg <= (tcp_reg && state_reg != DCC_CLOSED) ? DCC_CLOSING : DCC_CLOSED;
        end
        else if (open_cmd && !open_err && !open_rej)
        begin
            state_reg <= DCC_OPENING;
            // (R1) transport from selection
            tcp_reg <= cfg_reg[DCC_CFG_TRANSPORT];
            if (has_ip)
            begin
                dest_ip_reg <= arg_ip_reg;
                dest_port_reg <= arg_port_reg;
            end
            else if (incoming_since_reg)
            begin
                // (R5) reload stored settings
                dest_ip_reg <= set_ip_reg;
                dest_port_reg <= set_port_reg;
            end
            else
            begin
                // (R4) recent parameter endpoint
                dest_ip_reg <= param_ip_reg;
                dest_port_reg <= param_port_reg;
            end
        end
        else
        begin
            unique case (state_reg)
                DCC_CLOSED:
                    if (i_incoming_accepted)
                        state_reg <= DCC_ESTABLISHED;
                DCC_OPENING:
                    if (i_link_down)
                        state_reg <= DCC_CLOSED;
                    else if (i_link_up)
                        state_reg <= DCC_ESTABLISHED;
                DCC_ESTABLISHED:
                    if (i_link_down)
                        state_reg <= DCC_CLOSED;
                DCC_CLOSING:
                    if (i_link_down)
                        state_reg <= DCC_CLOSED;
            endcase
        end
    end

    // Transport action pulses: syn, udp, fin, rst, udp drop
    always_ff @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
            pulse_reg <= 5'h0;
        else
        begin
            // (R6) SYN for TCP, empty datagram for UDP
            pulse_reg[0] <= open_cmd && !open_err && !open_rej && cfg_reg[DCC_CFG_TRANSPORT];
            pulse_reg[1] <= open_cmd && !open_err && !open_rej && !cfg_reg[DCC_CFG_TRANSPORT];
            // (R13) FIN on close of TCP
            pulse_reg[2] <= drop_cmd && (op == DCC_OP_CLOSE) && tcp_reg
                && (state_reg != DCC_CLOSED);
            // (R14) RST on abort of TCP
            pulse_reg[3] <= drop_cmd && (op == DCC_OP_ABORT) && tcp_reg
                && (state_reg != DCC_CLOSED);
            pulse_reg[4] <= drop_cmd && !tcp_reg && (state_reg != DCC_CLOSED);
        end
    end

    // Reply code and overflow flags
    always_ff @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
            reply_reg <= DCC_REPLY_NONE;
        else if (drop_cmd)
            // (R17) close and abort always OK
            reply_reg <= DCC_REPLY_OK;
        else if (open_cmd)
        begin
            // (R8) error first, (R12) role gate inside rejection
            if (open_err)
                reply_reg <= DCC_REPLY_ERR;
            else if (open_rej)
                reply_reg <= DCC_REPLY_REJ;
            else
                // (R7) OK on acceptance
                reply_reg <= DCC_REPLY_OK;
        end
        else if (cmd_wr)
            reply_reg <= DCC_REPLY_ERR;
    end

    always_ff @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
            ovf_reg <= 2'h0;
        // (R15) clear overflow; a same-cycle overflow still sets
        else if (drop_cmd)
            ovf_reg <= i_ovf_set;
        else
            ovf_reg <= ovf_reg | i_ovf_set;
    end

    // Sticky interrupts: set wins over write-one-to-clear
    always_ff @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
            irq_stat_reg <= 3'h0;
        else
        begin
            logic [2:0] clr;
            logic [2:0] set;
            clr = wr_hit(DCC_OFS_IRQ_STAT) ? i_writedata[2:0] : 3'h0;
            set = {state_reg != DCC_CLOSED && i_link_down,
                   state_reg == DCC_OPENING && i_link_up && !drop_cmd,
                   cmd_wr};
            irq_stat_reg <= (irq_stat_reg & ~clr) | set;
        end
    end

    // Read mux
    always_comb
    begin
        rdata_next = 32'h0;
        unique case (i_address)
            DCC_OFS_ARG_IP: rdata_next = arg_ip_reg;
            DCC_OFS_ARG_PORT: rdata_next = {16'h0, arg_port_reg};
            DCC_OFS_CFG: rdata_next = {28'h0, cfg_reg};
            DCC_OFS_PARAM_IP: rdata_next = param_ip_reg;
            DCC_OFS_PARAM_PORT: rdata_next = {16'h0, param_port_reg};
            DCC_OFS_SET_IP: rdata_next = set_ip_reg;
            DCC_OFS_SET_PORT: rdata_next = {16'h0, set_port_reg};
            DCC_OFS_STATUS: rdata_next = {17'h0, ovf_reg, o_conn_flag, reply_reg,
                                          2'h0, state_reg};
            DCC_OFS_IRQ_STAT: rdata_next = {29'h0, irq_stat_reg};
            DCC_OFS_IRQ_MASK: rdata_next = {29'h0, irq_mask_reg};
            DCC_OFS_DEST_IP: rdata_next = dest_ip_reg;
            DCC_OFS_DEST_PORT: rdata_next = {16'h0, dest_port_reg};
            default: rdata_next = 32'h0;
        endcase
    end

    // Read data registered but valid at the accepting edge is not possible
    // with zero wait, so readdata is taken combinationally from the registers
    assign o_readdata = i_read ? rdata_next : 32'h0;

    assign o_tcp_syn = pulse_reg[0];
    assign o_udp_empty_dgram = pulse_reg[1];
    assign o_tcp_fin = pulse_reg[2];
    assign o_tcp_rst = pulse_reg[3];
    assign o_udp_drop = pulse_reg[4];
    assign o_dest_ip = dest_ip_reg;
    assign o_dest_port = dest_port_reg;
    assign o_ovf_flags = ovf_reg;
    // (R19) connection flag from state
    assign o_conn_flag = (state_reg == DCC_ESTABLISHED);
    assign o_irq = |(irq_stat_reg & irq_mask_reg);

    // Assertions
    open_reject_a: // (R10)
    assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        open_cmd && !drop_cmd && state_reg != DCC_CLOSED |=> reply_reg == DCC_REPLY_REJ
            || reply_reg == DCC_REPLY_ERR)
    else $error("open accepted while not closed");

    server_role_a: // (R11)
    assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        open_cmd && role == DCC_ROLE_SERVER && !open_err |=> reply_reg == DCC_REPLY_REJ
            && !o_tcp_syn && !o_udp_empty_dgram)
    else $error("open in server role not rejected");

    partial_dest_a: // (R3)
    assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        open_cmd && (has_ip != has_port) |=> reply_reg == DCC_REPLY_ERR
            && !o_tcp_syn && !o_udp_empty_dgram)
    else $error("partial destination accepted");

    auto_addr_a: // (R9)
    assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        open_cmd && !open_err && cfg_reg[DCC_CFG_AUTO_ADDR] && !i_addr_obtained
            |=> reply_reg == DCC_REPLY_REJ)
    else $error("open without address not rejected");

    open_start_a: // (R6)
    assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        open_cmd && !open_err && !open_rej |=> state_reg == DCC_OPENING
            && reply_reg == DCC_REPLY_OK && (o_tcp_syn ^ o_udp_empty_dgram))
    else $error("accepted open did not start transport");

    drop_ok_a: // (R17)
    assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        drop_cmd |=> reply_reg == DCC_REPLY_OK)
    else $error("close or abort not answered OK");

    ovf_clear_a: // (R15)
    assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        drop_cmd && i_ovf_set == 2'h0 |=> ovf_reg == 2'h0)
    else $error("overflow flags not cleared");

    param_lock_a: // (R18)
    assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        state_reg != DCC_CLOSED && !drop_cmd |=> $stable(param_ip_reg)
            && $stable(param_port_reg))
    else $error("destination parameter changed while connected");

    tcp_rst_a: // (R14)
    assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        drop_cmd && op == DCC_OP_ABORT && tcp_reg && state_reg != DCC_CLOSED
            |=> o_tcp_rst && !o_tcp_fin ##1 (!o_tcp_rst || $past(drop_cmd)))
    else $error("abort did not send a single reset");

    endpoint_a: // (R4)
    assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        open_cmd && !open_err && !open_rej && !has_ip && !incoming_since_reg
            |=> o_dest_ip == $past(param_ip_reg) && o_dest_port == $past(param_port_reg))
    else $error("wrong parameter endpoint");

endmodule : dcc_conn_ctrl

// ===== rtl/dcc_pkg.sv
package dcc_pkg;
    // Register byte offsets
    localparam logic [5:0] DCC_OFS_CMD = 6'h00;
    localparam logic [5:0] DCC_OFS_ARG_IP = 6'h04;
    localparam logic [5:0] DCC_OFS_ARG_PORT = 6'h08;
    localparam logic [5:0] DCC_OFS_CFG = 6'h0c;
    localparam logic [5:0] DCC_OFS_PARAM_IP = 6'h10;
    localparam logic [5:0] DCC_OFS_PARAM_PORT = 6'h14;
    localparam logic [5:0] DCC_OFS_SET_IP = 6'h18;
    localparam logic [5:0] DCC_OFS_SET_PORT = 6'h1c;
    localparam logic [5:0] DCC_OFS_STATUS = 6'h20;
    localparam logic [5:0] DCC_OFS_IRQ_STAT = 6'h24;
    localparam logic [5:0] DCC_OFS_IRQ_MASK = 6'h28;
    localparam logic [5:0] DCC_OFS_DEST_IP = 6'h2c;
    localparam logic [5:0] DCC_OFS_DEST_PORT = 6'h30;
    // Command register fields
    localparam int DCC_CMD_OP_LSB = 0;
    localparam int DCC_CMD_HAS_IP = 4;
    localparam int DCC_CMD_HAS_PORT = 5;
    localparam int DCC_CMD_PORT_HI = 6;
    // Config register fields
    localparam int DCC_CFG_ROLE_LSB = 0;
    localparam int DCC_CFG_TRANSPORT = 2;
    localparam int DCC_CFG_AUTO_ADDR = 3;
    // Status register fields
    localparam int DCC_ST_STATE_LSB = 0;
    localparam int DCC_ST_REPLY_LSB = 4;
    localparam int DCC_ST_CONN = 12;
    localparam int DCC_ST_OVF_LSB = 13;
    // Reset values
    localparam logic [3:0] DCC_CFG_RST = 4'h1;
    localparam logic [2:0] DCC_IRQ_MASK_RST = 3'h0;
    // Opcodes written to the command register
    localparam logic [3:0] DCC_OP_OPEN = 4'h1;
    localparam logic [3:0] DCC_OP_CLOSE = 4'h2;
    localparam logic [3:0] DCC_OP_ABORT = 4'h3;
    // Reply codes, ASCII
    localparam logic [7:0] DCC_REPLY_OK = 8'h41;
    localparam logic [7:0] DCC_REPLY_ERR = 8'h43;
    localparam logic [7:0] DCC_REPLY_REJ = 8'h52;
    localparam logic [7:0] DCC_REPLY_NONE = 8'h00;
    // Routing roles
    localparam logic [1:0] DCC_ROLE_SERVER = 2'h0;
    localparam logic [1:0] DCC_ROLE_BOTH = 2'h1;
    localparam logic [1:0] DCC_ROLE_CLIENT = 2'h2;
    // Interrupt bits
    localparam int DCC_IRQ_REPLY = 0;
    localparam int DCC_IRQ_UP = 1;
    localparam int DCC_IRQ_DOWN = 2;
    // Connection states, Gray along closed-opening-established-closing
    typedef enum logic [1:0] {
        DCC_CLOSED = 2'b00,
        DCC_OPENING = 2'b01,
        DCC_ESTABLISHED = 2'b11,
        DCC_CLOSING = 2'b10
    } dcc_state_t;
endpackage : dcc_pkg
